/* src/bflpe_engine.sv */
// Line parameter engine: line memories, sequencer and eight channels
//
// Overview of operation
// - Thirteen-bit channel delay counted after trigger
// - Launch delay is programmed delay plus fixed latency
// - Ten-bit pointer picks first word, MSB first
// - Receive enable turns switch on after transmit
// - 128 profile entries shared by all channels
// - Each line command's profile index used next
// - End symbol increments cycles and reloads pointer
// - Stop at stored repeat count, 256 maximum
// - End symbol never driven onto outputs
// - Six-bit duration holds samples 1 to 64
// - Delay resolution stays one clock period
// - Continuous mode repeats while trigger high
// - Two-bit drive field selects four currents
// - Sequencer repeats line then advances both indices
// - Invert bit inverts every second repeat of a line
// - Repeat two with invert: normal then inverted
// - Low-drop bit closes the bypass switch
// - Trigger low clears counters; rising edge starts
// - Sample pair 11 marks pattern end
// - Drive code 00 strongest through 11 weakest
`timescale 1ns/1ps
`default_nettype none
module bflpe_engine (
   input  wire logic                                 mclk,
   input  wire logic                                 reset,
   input  wire logic                                 fire_trigger,
   input  wire logic                                 lrec_we,
   input  wire logic [bflpe_pkg::CH_W-1:0]           lrec_chan,
   input  wire logic [bflpe_pkg::LREC_IDX_W-1:0]     lrec_addr,
   input  wire bflpe_pkg::bflpe_lrec_t                lrec_wdata,
   output var  bflpe_pkg::bflpe_lrec_t                lrec_rdata,
   input  wire logic                                 lprof_we,
   input  wire logic [bflpe_pkg::LPROF_IDX_W-1:0]    lprof_addr,
   input  wire bflpe_pkg::bflpe_lprof_t               lprof_wdata,
   output var  bflpe_pkg::bflpe_lprof_t               lprof_rdata,
   input  wire logic                                 wt_we,
   input  wire logic [bflpe_pkg::CH_W-1:0]           wt_chan,
   input  wire logic [bflpe_pkg::PTR_W-1:0]          wt_addr,
   input  wire logic [bflpe_pkg::WT_WIDTH-1:0]       wt_wdata,
   input  wire logic                                 cmd_valid,
   input  wire bflpe_pkg::bflpe_cmd_t                 cmd,
   input  wire logic                                 seq_enable,
   output logic [bflpe_pkg::NCH-1:0][1:0]            pulse_out,
   output logic [bflpe_pkg::NCH-1:0]                 tr_switch_on,
   output logic [bflpe_pkg::NCH-1:0]                 low_drop_bypass_switch,
   output logic                                      drive_strength_hi,
   output logic                                      drive_strength_lo,
   output logic                                      line_busy,
   output logic                                      line_inverted,
   output logic [bflpe_pkg::LREC_IDX_W-1:0]          active_lrec_index,
   output logic [bflpe_pkg::LPROF_IDX_W-1:0]         active_lprof_index
);
   // Whole control state of the engine
   typedef struct packed {
      logic [bflpe_pkg::LREC_IDX_W-1:0]         lr_idx;
      logic [bflpe_pkg::LPROF_IDX_W-1:0]        lp_idx;
      logic                                     cmd_inv;
      logic                                     load_pend;
      bflpe_pkg::bflpe_lprof_t                   prof;
      bflpe_pkg::bflpe_lrec_t [bflpe_pkg::NCH-1:0] rec;
      logic [bflpe_pkg::SEQ_W-1:0]              line_cnt;
      logic                                     line_inv;
      logic                                     fire_trigger_q;
   } bflpe_eng_reg_t;

   bflpe_eng_reg_t state;
   bflpe_eng_reg_t next_state;

   // Line memories; the profile store is one bank for every channel
   bflpe_pkg::bflpe_lrec_t  line_record_word
      [bflpe_pkg::NCH][bflpe_pkg::LREC_DEPTH];
   bflpe_pkg::bflpe_lprof_t line_profile_word
      [bflpe_pkg::LPROF_DEPTH];

   logic                      fire_trigger_level;
   logic                      fire_trigger_rise;
   logic                      fire_trigger_fall;
   logic                      line_end_step;
   logic [bflpe_pkg::NCH-1:0] ch_busy;
   logic [bflpe_pkg::NCH-1:0] wt_sel;
   logic [bflpe_pkg::SEQ_W-1:0] line_cnt_inc;

   // Pin trigger passes three stages; this sets the fixed latency
   bflpe_sync u_fire_trigger_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in (fire_trigger),
      .level    (fire_trigger_level),
      .rise     (fire_trigger_rise)
   );

   // Host writes to the line-record banks, out-of-range addresses dropped
   always_ff @(posedge mclk) begin
      if (lrec_we && lrec_addr <= bflpe_pkg::LREC_LAST) begin
         line_record_word[lrec_chan][lrec_addr] <= lrec_wdata;
      end
   end

   // Host writes to the profile store
   always_ff @(posedge mclk) begin
      if (lprof_we) begin
         line_profile_word[lprof_addr] <= lprof_wdata;
      end
   end

   // Read-back of both memories, one cycle after the address
   always_ff @(posedge mclk) begin
      if (reset) begin
         lrec_rdata  <= bflpe_pkg::LREC_RESET;
         lprof_rdata <= bflpe_pkg::LPROF_RESET;
      end else begin
         if (lrec_addr <= bflpe_pkg::LREC_LAST) begin
            lrec_rdata <= line_record_word[lrec_chan][lrec_addr];
         end else begin
            lrec_rdata <= bflpe_pkg::LREC_RESET;
         end
         lprof_rdata <= line_profile_word[lprof_addr];
      end
   end

   // A line ends when the filtered trigger falls
   assign fire_trigger_fall     = state.fire_trigger_q & ~fire_trigger_level;
   assign line_end_step = fire_trigger_fall & seq_enable & ~cmd_valid;
   assign line_cnt_inc  = state.line_cnt + 5'h01;

   // Command, sequencer and parameter load
   always_comb begin
      next_state        = state;
      next_state.fire_trigger_q = fire_trigger_level;
      if (cmd_valid) begin
         // The command names the profile for the next line
         next_state.lr_idx    = cmd.lrec_index;
         next_state.lp_idx    = cmd.lprof_index;
         next_state.cmd_inv   = cmd.invert;
         next_state.load_pend = 1'b1;
         next_state.line_cnt  = '0;
         next_state.line_inv  = 1'b0;
      end else if (line_end_step) begin
         // Count zero stands for 32 repetitions, as the field wraps
         if (line_cnt_inc == state.prof.seq_repeat) begin
            next_state.line_cnt  = '0;
            next_state.line_inv  = 1'b0;
            next_state.lp_idx    = state.lp_idx + 7'h01;
            next_state.load_pend = 1'b1;
            if (state.lr_idx == bflpe_pkg::LREC_LAST) begin
               next_state.lr_idx = '0;
            end else begin
               next_state.lr_idx = state.lr_idx + 11'h001;
            end
         end else begin
            next_state.line_cnt = line_cnt_inc;
            // Odd repeats of a line fire inverted
            next_state.line_inv = state.prof.invert_line &
                                  line_cnt_inc[0];
         end
      end
      // Parameters change only between lines so a burst stays coherent
      if (state.load_pend && !fire_trigger_level && !cmd_valid) begin
         next_state.prof      = line_profile_word[state.lp_idx];
         next_state.load_pend = 1'b0;
         for (int i = 0; i < bflpe_pkg::NCH; i++) begin
            next_state.rec[i] = line_record_word[i][state.lr_idx];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Per-channel table write select
   always_comb begin
      wt_sel = '0;
      wt_sel[wt_chan] = wt_we;
   end

   // Eight identical channels share one profile and trigger
   for (genvar g = 0; g < bflpe_pkg::NCH; g++) begin : g_ch
      bflpe_channel u_ch (
         .mclk         (mclk),
         .reset        (reset),
         .fire_trigger_level   (fire_trigger_level),
         .fire_trigger_rise    (fire_trigger_rise),
         .lrec         (state.rec[g]),
         .lprof        (state.prof),
         .invert       (state.cmd_inv ^ state.line_inv),
         .wt_we        (wt_sel[g]),
         .wt_addr      (wt_addr),
         .wt_wdata     (wt_wdata),
         .pulse        (pulse_out[g]),
         .tr_switch_on (tr_switch_on[g]),
         .busy         (ch_busy[g])
      );
   end

   // Bypass switch follows the loaded low-drop bit, open after reset
   assign low_drop_bypass_switch = {bflpe_pkg::NCH{state.prof.low_drop}};

   // Code 00 is the strongest current and 11 the weakest
   assign drive_strength_hi  = state.prof.drive_strength_hi;
   assign drive_strength_lo  = state.prof.drive_strength_lo;

   // Status for the host
   assign line_busy          = |ch_busy;
   assign line_inverted      = state.cmd_inv ^ state.line_inv;
   assign active_lrec_index  = state.lr_idx;
   assign active_lprof_index = state.lp_idx;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // A command followed by a quiet cycle with the trigger low
   sequence seq_cmd_quiet;
      (cmd_valid && !fire_trigger_level) ##1 (!cmd_valid && !fire_trigger_level);
   endsequence

   AST_CMD_LOAD: assert property (
      seq_cmd_quiet |=> (state.lp_idx == $past(cmd.lprof_index, 2) &&
                         !state.load_pend))
      else $error("commanded profile not loaded");

   // End of a line whose repeat count is used up
   sequence seq_line_last;
      line_end_step && line_cnt_inc == state.prof.seq_repeat &&
      state.lr_idx != bflpe_pkg::LREC_LAST;
   endsequence

   AST_SEQ_ADVANCE: assert property (
      seq_line_last |=> (state.line_cnt == '0 &&
                         state.lr_idx == $past(state.lr_idx) + 11'h001 &&
                         state.lp_idx == $past(state.lp_idx) + 7'h01))
      else $error("sequencer did not advance both indices");

   AST_SEQ_INVERT: assert property (
      (line_end_step && state.prof.invert_line &&
       state.prof.seq_repeat == 5'h02 && state.line_cnt == '0)
      |=> state.line_inv)
      else $error("second line of a pair not inverted");

   AST_SEQ_NO_INVERT: assert property (
      (line_end_step && !state.prof.invert_line) |=> !state.line_inv)
      else $error("line inverted with invert bit low");

   // Switch must take the stored bit at the load, then hold a cycle
   AST_LOWDROP: assert property (
      (state.load_pend && !fire_trigger_level && !cmd_valid)
      |=> (low_drop_bypass_switch == {bflpe_pkg::NCH{
             $past(line_profile_word[state.lp_idx].low_drop)}})
          ##1 $stable(low_drop_bypass_switch))
      else $error("bypass switch does not follow profile");
endmodule
`default_nettype wire

/* common/bflpe_pkg.sv */
// Constants and carriers shared by the line parameter engine
package bflpe_pkg;
   localparam int NCH         = 8;
   localparam int LREC_DEPTH  = 1536;
   localparam int LPROF_DEPTH = 128;
   localparam int WT_DEPTH    = 1024;
   localparam int WT_WIDTH    = 16;
   localparam int DLY_W       = 13;
   localparam int PTR_W       = 10;
   localparam int REP_W       = 8;
   localparam int DUR_W       = 6;
   localparam int SEQ_W       = 5;
   localparam int LREC_IDX_W  = 11;
   localparam int LPROF_IDX_W = 7;
   localparam int CH_W        = 3;
   localparam int SIDX_W      = 3;
   localparam logic [10:0] LREC_LAST          = 11'h5ff;
   localparam logic [1:0]  PATTERN_END_SYMBOL = 2'b11;
   localparam logic [1:0]  SAMPLE_IDLE        = 2'h0;
   localparam logic [2:0]  SIDX_LAST          = 3'h7;
   localparam logic [23:0] LPROF_RESET        = 24'h000000;
   localparam logic [23:0] LREC_RESET         = 24'h000000;

   // Line record word, delay in the top bits, receive enable at bit 0
   typedef struct packed {
      logic [DLY_W-1:0] beam_delay_count;
      logic [PTR_W-1:0] pattern_start_pointer;
      logic             rx_enable;
   } bflpe_lrec_t;

   // Line profile word, common to every channel
   typedef struct packed {
      logic             low_drop;
      logic             invert_line;
      logic [SEQ_W-1:0] seq_repeat;
      logic             drive_strength_hi;
      logic             drive_strength_lo;
      logic             continuous_wave_mode;
      logic [DUR_W-1:0] sample_duration;
      logic [REP_W-1:0] repeat_count;
   } bflpe_lprof_t;

   // Line-select command
   typedef struct packed {
      logic [LREC_IDX_W-1:0]  lrec_index;
      logic [LPROF_IDX_W-1:0] lprof_index;
      logic                   invert;
   } bflpe_cmd_t;

   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_WAIT = 2'b01,
      CH_PLAY = 2'b10,
      CH_DONE = 2'b11
   } bflpe_ch_state_t;
endpackage

/* src/bflpe_sync.sv */
// Three-stage trigger synchroniser with agreement filter and edge pulse
`timescale 1ns/1ps
`default_nettype none
module bflpe_sync (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   typedef struct packed {
      logic [2:0] stage;
      logic       level;
      logic       rise;
   } bflpe_sync_state_t;

   bflpe_sync_state_t state;
   bflpe_sync_state_t next_state;

   // Stage 0 feeds stage 1 only; a change counts once 1 and 2 agree
   always_comb begin
      next_state       = state;
      next_state.stage = {state.stage[1:0], async_in};
      next_state.rise  = 1'b0;
      if (state.stage[2] == state.stage[1]) begin
         next_state.level = state.stage[2];
         next_state.rise  = state.stage[2] & ~state.level;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.level;
   assign rise  = state.rise;
endmodule
`default_nettype wire

/* src/bflpe_channel.sv */
// One channel: delay count, waveform playback and receive switch
`timescale 1ns/1ps
`default_nettype none
module bflpe_channel (
   input  wire logic                   mclk,
   input  wire logic                   reset,
   input  wire logic                   fire_trigger_level,
   input  wire logic                   fire_trigger_rise,
   input  wire bflpe_pkg::bflpe_lrec_t  lrec,
   input  wire bflpe_pkg::bflpe_lprof_t lprof,
   input  wire logic                   invert,
   input  wire logic                   wt_we,
   input  wire logic [9:0]             wt_addr,
   input  wire logic [15:0]            wt_wdata,
   output logic [1:0]                  pulse,
   output logic                        tr_switch_on,
   output logic                        busy
);
   typedef struct packed {
      bflpe_pkg::bflpe_ch_state_t    st;
      logic [bflpe_pkg::DLY_W-1:0]  cnt;
      logic [bflpe_pkg::DUR_W-1:0]  hold;
      logic [bflpe_pkg::PTR_W-1:0]  ptr;
      logic [bflpe_pkg::SIDX_W-1:0] idx;
      logic [bflpe_pkg::REP_W-1:0]  cyc;
      logic [1:0]                   pulse;
      logic                         tr;
   } bflpe_ch_reg_t;

   bflpe_ch_reg_t state;
   bflpe_ch_reg_t next_state;
   logic [15:0]   waveform_table [bflpe_pkg::WT_DEPTH];
   logic [15:0]   word;
   logic [1:0]    sample;
   logic          is_end;

   always_ff @(posedge mclk) begin
      if (wt_we) begin
         waveform_table[wt_addr] <= wt_wdata;
      end
   end

   // Samples leave most significant first within each word
   assign word   = waveform_table[state.ptr];
   assign sample = word[{~state.idx, 1'b1} -: 2];
   assign is_end = (sample == bflpe_pkg::PATTERN_END_SYMBOL);

   always_comb begin
      next_state       = state;
      next_state.pulse = bflpe_pkg::SAMPLE_IDLE;
      if (!fire_trigger_level) begin
         // Trigger low keeps the counters cleared
         next_state.st  = bflpe_pkg::CH_IDLE;
         next_state.cnt = '0;
         next_state.cyc = '0;
      end else begin
         case (state.st)
            bflpe_pkg::CH_IDLE: begin
               if (fire_trigger_rise) begin
                  next_state.st  = bflpe_pkg::CH_WAIT;
                  next_state.cnt = lrec.beam_delay_count;
                  next_state.tr  = 1'b0;
               end
            end
            bflpe_pkg::CH_WAIT: begin
               // One count per clock whatever the sample duration
               if (state.cnt == '0) begin
                  next_state.st   = bflpe_pkg::CH_PLAY;
                  next_state.ptr  = lrec.pattern_start_pointer;
                  next_state.idx  = '0;
                  next_state.hold = '0;
                  next_state.cyc  = '0;
               end else begin
                  next_state.cnt = state.cnt - 13'h1;
               end
            end
            bflpe_pkg::CH_PLAY: begin
               // End symbol is a loop marker; its slot shows idle
               if (is_end) begin
                  if (lprof.continuous_wave_mode ||
                      (state.cyc + 8'h01) != lprof.repeat_count) begin
                     next_state.cyc = state.cyc + 8'h01;
                     next_state.ptr = lrec.pattern_start_pointer;
                     next_state.idx = '0;
                  end else begin
                     next_state.st = bflpe_pkg::CH_DONE;
                     next_state.tr = lrec.rx_enable;
                  end
               end else begin
                  next_state.pulse = invert ? {sample[0], sample[1]} : sample;
                  // Duration N holds each sample N plus one clocks
                  if (state.hold == lprof.sample_duration) begin
                     next_state.hold = '0;
                     next_state.idx  = state.idx + 3'h1;
                     if (state.idx == bflpe_pkg::SIDX_LAST) begin
                        next_state.ptr = state.ptr + 10'h1;
                     end
                  end else begin
                     next_state.hold = state.hold + 6'h01;
                  end
               end
            end
            bflpe_pkg::CH_DONE: begin
               next_state.st = bflpe_pkg::CH_DONE;
            end
            default: begin
               next_state.st = bflpe_pkg::CH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pulse        = state.pulse;
   assign tr_switch_on = state.tr;
   assign busy         = (state.st == bflpe_pkg::CH_WAIT) ||
                         (state.st == bflpe_pkg::CH_PLAY);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   AST_CH_DELAY_STEP: assert property (
      (state.st == bflpe_pkg::CH_WAIT && state.cnt != '0 && fire_trigger_level)
      |=> state.cnt == $past(state.cnt) - 13'h1)
      else $error("delay counter did not step by one");
   AST_CH_NO_END_OUT: assert property (
      pulse != bflpe_pkg::PATTERN_END_SYMBOL)
      else $error("end symbol driven on channel");
   AST_CH_HOLD: assert property (
      (state.st == bflpe_pkg::CH_PLAY && !is_end && fire_trigger_level &&
       state.hold != lprof.sample_duration)
      |=> state.idx == $past(state.idx))
      else $error("sample advanced before its hold ended");
   AST_CH_CW_RELOAD: assert property (
      (state.st == bflpe_pkg::CH_PLAY && is_end && fire_trigger_level &&
       lprof.continuous_wave_mode)
      |=> state.st == bflpe_pkg::CH_PLAY && state.idx == '0)
      else $error("continuous mode did not reload");
   AST_CH_STOP: assert property (
      (state.st == bflpe_pkg::CH_PLAY && is_end && fire_trigger_level &&
       !lprof.continuous_wave_mode &&
       (state.cyc + 8'h01) == lprof.repeat_count)
      |=> state.st == bflpe_pkg::CH_DONE)
      else $error("repetition did not stop at the count");
   AST_CH_FIRE_TRIGGER_LOW: assert property (
      !fire_trigger_level |=> state.st == bflpe_pkg::CH_IDLE && state.cyc == '0)
      else $error("counters not cleared with trigger low");
endmodule
`default_nettype wire

/* verif/bflpe_host.sv */
// Host model: line-select commands and trigger pin
`timescale 1ns/1ps
`default_nettype none
module bflpe_host (
   input  wire logic              mclk,
   output logic                   fire_trigger,
   output logic                   cmd_valid,
   output var bflpe_pkg::bflpe_cmd_t cmd
);
   initial begin
      fire_trigger = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // Idle bus shows inverted junk so stale values never look valid
   task automatic send_cmd(input logic [10:0] lr, input logic [6:0] lp,
                           input logic inv);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd = {lr, lp, inv};
      @(negedge mclk);
      cmd_valid = 1'b0;
      cmd = ~cmd;
      repeat (3) @(negedge mclk);
   endtask
   // Trigger moves on the falling edge, sampled on the rising one
   task automatic set_trigger(input logic v);
      @(negedge mclk);
      fire_trigger = v;
   endtask
endmodule
`default_nettype wire

/* verif/bflpe_engine_tb.sv */
// Self-checking bench for the line parameter engine
`timescale 1ns/1ps
`default_nettype none
module bflpe_engine_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic fire_trigger, cmd_valid, lrec_we, lprof_we, wt_we, seq_enable;
   logic [2:0] lrec_chan, wt_chan;
   logic [10:0] lrec_addr, active_lrec_index;
   logic [6:0] lprof_addr, active_lprof_index;
   logic [9:0] wt_addr;
   logic [15:0] wt_wdata;
   bflpe_pkg::bflpe_lrec_t lrec_wdata, lrec_rdata;
   bflpe_pkg::bflpe_lprof_t lprof_wdata, lprof_rdata;
   bflpe_pkg::bflpe_cmd_t cmd;
   logic [7:0][1:0] pulse_out;
   logic [7:0] tr_switch_on, low_drop_bypass_switch;
   logic drive_strength_hi, drive_strength_lo, line_busy, line_inverted;
   logic [7:0][1:0] trace [0:79];
   int mismatches = 0;
   int samples_checked = 0;

   always #5 mclk = ~mclk;

   bflpe_engine uut (.mclk, .reset, .fire_trigger, .lrec_we, .lrec_chan,
      .lrec_addr, .lrec_wdata, .lrec_rdata, .lprof_we, .lprof_addr,
      .lprof_wdata, .lprof_rdata, .wt_we, .wt_chan, .wt_addr, .wt_wdata,
      .cmd_valid, .cmd, .seq_enable, .pulse_out, .tr_switch_on,
      .low_drop_bypass_switch, .drive_strength_hi, .drive_strength_lo,
      .line_busy, .line_inverted, .active_lrec_index, .active_lprof_index);
   bflpe_host host (.mclk, .fire_trigger, .cmd_valid, .cmd);

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Memory writes: one word per strobe, strobe dropped next cycle
   task automatic wr_rec(input logic [2:0] ch, input logic [10:0] a,
                         input logic [23:0] d);
      @(negedge mclk);
      {lrec_we, lrec_chan, lrec_addr, lrec_wdata} = {1'b1, ch, a, d};
      @(negedge mclk);
      lrec_we = 1'b0;
   endtask
   task automatic wr_prof(input logic [6:0] a, input logic [23:0] d);
      @(negedge mclk);
      {lprof_we, lprof_addr, lprof_wdata} = {1'b1, a, d};
      @(negedge mclk);
      lprof_we = 1'b0;
   endtask

   task automatic t_regs;
      wr_rec(3'h2, 11'h5ff, 24'habcdef);
      wr_rec(3'h2, 11'h600, 24'h123456);
      wr_prof(7'h7f, 24'h5a5a5a);
      lrec_addr = 11'h5ff;
      @(negedge mclk);
      check("lrec_rdata", lrec_rdata, 32'habcdef);
      check("lprof_rdata", lprof_rdata, 32'h5a5a5a);
      lrec_addr = 11'h600;
      @(negedge mclk);
      check("lrec_unmapped", lrec_rdata, 32'h0);
   endtask

   // Channel c waits c clocks; pattern 01,10,end held 3 clocks, 2 cycles
   task automatic t_line;
      int f [8];
      int n1, n2, n3;
      for (int c = 0; c < 8; c++) begin
         @(negedge mclk);
         {wt_we, wt_chan, wt_addr, wt_wdata} = {1'b1, c[2:0], 26'h0036c00};
         wr_rec(c[2:0], 11'h0, {c[12:0], 10'h3, ~c[0]});
         wt_we = 1'b0;
      end
      wr_prof(7'h0, 24'h000202);
      host.send_cmd(11'h0, 7'h0, 1'b0);
      host.set_trigger(1'b1);
      for (int i = 0; i < 80; i++) begin
         @(negedge mclk);
         trace[i] = pulse_out;
      end
      for (int c = 0; c < 8; c++) begin
         f[c] = -1;
         {n1, n2, n3} = '0;
         for (int i = 0; i < 80; i++) begin
            n1 += int'(trace[i][c] === 2'b01);
            n2 += int'(trace[i][c] === 2'b10);
            n3 += int'(trace[i][c] === 2'b11);
            if (f[c] < 0 && trace[i][c] !== 2'b00) f[c] = i;
         end
         check("first_sample", trace[f[c]][c], 32'h1);
         check("launch_offset", f[c] - f[0], c);
         check("count_01", n1, 6);
         check("count_10", n2, 6);
         check("end_out", n3, 0);
         check("restart", {trace[f[c]+6][c], trace[f[c]+7][c]}, 1);
         check("tr_switch", tr_switch_on[c], !c[0]);
      end
      check("busy_done", line_busy, 0);
      host.set_trigger(1'b0);
      repeat (6) @(negedge mclk);
      check("pulse_idle", pulse_out, 0);
   endtask

   task automatic t_drive;
      for (int i = 0; i < 4; i++) begin
         wr_prof(7'(i + 1), {i[0], 6'h0, i[1:0], 15'h0});
         host.send_cmd(11'h0, 7'(i + 1), i[0]);
         check("drive", {drive_strength_hi, drive_strength_lo}, i);
         check("low_drop", low_drop_bypass_switch, {8{i[0]}});
         check("lprof_index", active_lprof_index, i + 1);
         check("cmd_invert", line_inverted, i[0]);
      end
   endtask

   // Continuous mode outlives the cycle count; trigger low stops it
   task automatic t_cw;
      wr_prof(7'h6, 24'h804001);
      host.send_cmd(11'h0, 7'h6, 1'b0);
      host.set_trigger(1'b1);
      repeat (60) @(negedge mclk);
      check("cw_busy", line_busy, 1);
      check("cw_low_drop", low_drop_bypass_switch, 8'hff);
      host.set_trigger(1'b0);
      repeat (6) @(negedge mclk);
      check("cw_stop", line_busy, 0);
      check("cw_idle", pulse_out, 0);
   endtask

   // Repeat two with invert: normal line, inverted line, then advance
   task automatic t_seq;
      logic [1:0] s;
      wr_prof(7'h5, 24'h440001);
      host.send_cmd(11'h0, 7'h5, 1'b0);
      seq_enable = 1'b1;
      for (int k = 0; k < 2; k++) begin
         host.set_trigger(1'b1);
         // First sample of channel 0 shows the line's polarity
         s = 2'b00;
         for (int i = 0; i < 30; i++) begin
            @(negedge mclk);
            if (s == 2'b00) begin
               s = pulse_out[0];
            end
         end
         check("seq_polarity", s, k ? 2'h2 : 2'h1);
         check("line_inverted", line_inverted, k);
         host.set_trigger(1'b0);
         repeat (10) @(negedge mclk);
      end
      check("seq_lrec", active_lrec_index, 1);
      check("seq_lprof", active_lprof_index, 6);
      seq_enable = 1'b0;
   endtask

   initial begin
      {lrec_we, lprof_we, wt_we, seq_enable} = '0;
      {lrec_chan, wt_chan, lrec_addr, lprof_addr, wt_addr} = '0;
      {wt_wdata, lrec_wdata, lprof_wdata} = '0;
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      t_regs;
      t_line;
      t_drive;
      t_cw;
      t_seq;
      tally_and_finish;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
